// file: bench/tsg_board.sv
// board model: pin levels seen by the port from drivers, pull-ups and board
`timescale 1ns/1ps
`default_nettype none
module tsg_board (
    // wide port
    input wire logic [7:0] wide_out,
    input wire logic [7:0] wide_oe,
    input wire logic [7:0] wide_pu,
    input wire logic [7:0] wide_ext,
    output logic [7:0] wide_level,
    // narrow port
    input wire logic [2:0] narrow_out,
    input wire logic [2:0] narrow_oe,
    input wire logic [2:0] narrow_pu,
    input wire logic [2:0] narrow_ext,
    output logic [2:0] narrow_level
);
    // a driven pin shows its driver, a released one its pull-up or the board
    assign wide_level = (wide_oe & wide_out)
        | (~wide_oe & (wide_pu | wide_ext));
    assign narrow_level = (narrow_oe & narrow_out)
        | (~narrow_oe & (narrow_pu | narrow_ext));
endmodule
`default_nettype wire

// file: bench/tsg_ports_tb.sv
// testbench for the timer and serial shared gpio ports
`timescale 1ns/1ps
`default_nettype none
module tsg_ports_tb;
    logic sys_clk, rstn, hw_standby, sw_standby, avs_read, avs_write;
    logic avs_waitrequest, t0c, t0r, t1c, t1r, tx, ckd, rxl, sck;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] wpi, wpo, woe, wpu, wsel, wtmr, wext, wdir, wdat, ndir, ndat;
    logic [2:0] npi, npo, noe, npu, ssel, soe, next_v;
    logic [7:0] wsel_v;
    logic [2:0] ssel_v;
    int bad_count, num_checks;
    ////////////////////////////////////////////////////////////////////
    tsg_ports dut_u (.sys_clk(sys_clk), .rstn(rstn),
        .hw_standby(hw_standby), .sw_standby(sw_standby),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wide_pin_in(wpi), .wide_pin_out(wpo), .wide_pin_oe(woe),
        .wide_pullup_en(wpu), .wide_tmr_sel(wsel), .wide_tmr_out(wtmr),
        .timer0_clock_in(t0c), .timer0_reset_in(t0r),
        .timer1_clock_in(t1c), .timer1_reset_in(t1r),
        .narrow_pin_in(npi), .narrow_pin_out(npo), .narrow_pin_oe(noe),
        .narrow_pullup_en(npu), .ser_sel(ssel), .ser_oe(soe),
        .async_transmit_line(tx), .async_clock_drive(ckd),
        .async_receive_line(rxl), .async_serial_clock(sck));
    tsg_board board_u (.wide_out(wpo), .wide_oe(woe), .wide_pu(wpu),
        .wide_ext(wext), .wide_level(wpi), .narrow_out(npo),
        .narrow_oe(noe), .narrow_pu(npu), .narrow_ext(next_v),
        .narrow_level(npi));
    ////////////////////////////////////////////////////////////////////
    // expected {pin, read, pull-up, driven value, enable} of the wide port
    function automatic logic [39:0] wide_exp(input logic [7:0] d, q, s, t);
        logic [7:0] m, oe, out, pin;
        m = s & tsg_pkg::WIDE_OUT_PINS & {8{~sw_standby}};
        oe = m | d;
        out = (m & t) | (~m & q);
        pin = (oe & out) | (~oe & (q | wext));
        return {pin, (d & q) | (~d & pin), ~oe & q, oe & out, oe};
    endfunction
    // same for the narrow port, serial claims taking over direction
    function automatic logic [39:0] narrow_exp(input logic [2:0] d, q);
        logic [2:0] m, oe, out, pu, pin;
        m = ssel & {3{~sw_standby}};
        oe = (~m & d) | (m & {soe[2], 1'b0, 1'b1});
        out = (~m & q) | (m & {ckd, 1'b0, tx});
        pu = ~oe & ~d & q;
        pin = (oe & out) | (~oe & (pu | next_v));
        return {5'h0, pin, 8'hf8 | {5'h0, (d & q) | (~d & pin)},
            5'h0, pu, 5'h0, oe & out, 5'h0, oe};
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %0t read %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %0t pins %h want %h", $time, g, e);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a,
        input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, wd};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            $display("unexpected %0t bus stall", $time);
        end
    endtask
    task automatic check_all();
        logic [39:0] we, ne;
        repeat (8) @(posedge sys_clk);
        #1;
        we = wide_exp(wdir, wdat, wsel, wtmr);
        ne = narrow_exp(ndir[2:0], ndat[2:0]);
        cmp_pin(woe, we[7:0]);
        cmp_pin(wpo & woe, we[15:8]);
        cmp_pin(wpu, we[23:16]);
        cmp_pin({4'h0, t1r, t1c, t0r, t0c},
            {4'h0, we[29], we[27], we[26], we[24]});
        cmp_pin({5'h0, noe}, ne[7:0]);
        cmp_pin({5'h0, npo & noe}, ne[15:8]);
        cmp_pin({5'h0, npu}, ne[23:16]);
        cmp_pin({6'h0, sck, rxl}, {6'h0, ne[34:33]});
        bus(1'b0, tsg_pkg::WIDE_DATA_OFF, 8'h00);
        cmp_rd(rd, {24'h0, we[31:24]});
        bus(1'b0, tsg_pkg::NARROW_DATA_OFF, 8'h00);
        cmp_rd(rd, {24'h0, ne[31:24]});
    endtask
    task automatic test_done();
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (6000) @(posedge sys_clk);
        bad_count++;
        $display("unexpected %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        {rstn, hw_standby, sw_standby, avs_read, avs_write, tx, ckd} = '0;
        {avs_address, avs_writedata, wsel, wtmr, ssel, soe} = '0;
        {wdir, wdat, ndir, ndat} = '0;
        wext = 8'ha5;
        next_v = 3'h5;
        bad_count = 0;
        num_checks = 0;
        void'($urandom(32'hf7c2));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        check_all();
        bus(1'b0, tsg_pkg::WIDE_DIR_OFF, 8'h00);
        cmp_rd(rd, 32'h0);
        bus(1'b0, tsg_pkg::NARROW_DIR_OFF, 8'h00);
        cmp_rd(rd, {24'h0, tsg_pkg::NARROW_RST});
        bus(1'b1, 16'hffb6, 8'hff);
        bus(1'b0, 16'hffb6, 8'h00);
        cmp_rd(rd, 32'h0);
        for (int i = 0; i < 40; i++) begin
            wdir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            wdat = (i < 2) ? 8'hff : 8'($urandom);
            ndir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            ndat = (i < 2) ? 8'hff : 8'($urandom);
            wsel_v = (i < 2) ? 8'h00 : 8'($urandom);
            ssel_v = (i < 2) ? 3'h0 : 3'($urandom);
            if (i[0]) begin
                wdir = wdir & ~(wsel_v & tsg_pkg::WIDE_IN_PINS);
            end
            if (ssel_v[2]) begin
                ndat[2] = 1'b0;
            end
            wsel <= wsel_v;
            ssel <= ssel_v;
            bus(1'b1, tsg_pkg::WIDE_DIR_OFF, wdir);
            bus(1'b1, tsg_pkg::WIDE_DATA_OFF, wdat);
            bus(1'b1, tsg_pkg::NARROW_DIR_OFF, ndir);
            bus(1'b1, tsg_pkg::NARROW_DATA_OFF, ndat);
            wext <= 8'($urandom);
            next_v <= 3'($urandom);
            wtmr <= 8'($urandom);
            soe <= 3'($urandom);
            tx <= 1'($urandom);
            ckd <= 1'($urandom);
            sw_standby <= (i % 4 == 3);
            check_all();
        end
        hw_standby <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_pin(woe | wpu, 8'h00);
        cmp_pin({5'h0, noe | npu}, 8'h00);
        @(posedge sys_clk);
        hw_standby <= 1'b0;
        sw_standby <= 1'b0;
        wsel <= 8'h00;
        ssel <= 3'h0;
        {wdir, wdat, ndir, ndat} = '0;
        check_all();
        test_done();
    end
endmodule
`default_nettype wire

// file: logic/tsg_pkg.sv
// package: register map and layout for the shared gpio ports
package tsg_pkg;
    localparam int WIDE_W = 8;
    localparam int NARROW_W = 3;
    localparam logic [15:0] WIDE_DIR_OFF = 16'hffb5;
    localparam logic [15:0] WIDE_DATA_OFF = 16'hffb7;
    localparam logic [15:0] NARROW_DIR_OFF = 16'hffb8;
    localparam logic [15:0] NARROW_DATA_OFF = 16'hffba;
    localparam logic [7:0] WIDE_RST = 8'h00;
    localparam logic [7:0] NARROW_RST = 8'hf8;
    localparam logic [7:0] NARROW_FILL = 8'hf8;
    // serial pin positions
    localparam int SER_TX_BIT = 0;
    localparam int SER_RX_BIT = 1;
    localparam int SER_CK_BIT = 2;
    // timer output pins of the wide port: bits 1,4,6,7
    localparam logic [7:0] WIDE_OUT_PINS = 8'hd2;
    // timer input pins: bits 0,2,3,5
    localparam logic [7:0] WIDE_IN_PINS = 8'h2d;
endpackage

// file: logic/tsg_ports.sv
// top: wide timer-shared port and narrow serial-shared port
// Operation
// - direction bit 1 drives pin, 0 makes it input; wide direction is 8 bits.
// - data reads return latch for outputs, pin level for inputs.
// - input pins get pull-up when latch bit is 1 and direction bit is 0, in every mode.
// - timer clock and reset inputs come from the port read path.
// - timer and pwm outputs drive pins directly, pull-up forced off.
// - reset or hardware standby clears wide registers to zero.
// - software standby keeps wide registers, pins act as plain port pins.
// - narrow port has three bits; upper bits read one, reset f8.
// - serial interface sets direction of pins it claims.
// - serial transmit drives bit 0 directly, pull-up forced off.
// - serial receive pin ignores registers except direction0 data1 pull-up.
// - serial clock pin ignores registers except direction0 data1 pull-up.
// - reset or hardware standby makes narrow pins inputs, no pull-up.
// - software standby keeps narrow registers, pins act as plain port pins.
// - narrow pin sharing is dropped in software and hardware standby.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tsg_ports (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // power modes
    input wire logic hw_standby,
    input wire logic sw_standby,
    // avalon-mm slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // wide port pins
    input wire logic [7:0] wide_pin_in,
    output logic [7:0] wide_pin_out,
    output logic [7:0] wide_pin_oe,
    output logic [7:0] wide_pullup_en,
    // wide port timer side
    input wire logic [7:0] wide_tmr_sel,
    input wire logic [7:0] wide_tmr_out,
    output logic timer0_clock_in,
    output logic timer0_reset_in,
    output logic timer1_clock_in,
    output logic timer1_reset_in,
    // narrow port pins
    input wire logic [2:0] narrow_pin_in,
    output logic [2:0] narrow_pin_out,
    output logic [2:0] narrow_pin_oe,
    output logic [2:0] narrow_pullup_en,
    // narrow port serial side
    input wire logic [2:0] ser_sel,
    input wire logic [2:0] ser_oe,
    input wire logic async_transmit_line,
    input wire logic async_clock_drive,
    output logic async_receive_line,
    output logic async_serial_clock
);
    localparam int WW = tsg_pkg::WIDE_W;
    localparam int NW = tsg_pkg::NARROW_W;

    logic [7:0] wdir_r;
    logic [7:0] wdat_r;
    logic [2:0] ndir_r;
    logic [2:0] ndat_r;
    logic [7:0] wide_sync;
    logic [2:0] narrow_sync;
    logic [7:0] wide_rd;
    logic [2:0] narrow_rd;
    logic [7:0] rd_nxt;
    logic ack_r;
    logic req;
    logic hw_clr;

    ////////////////////////////////////////////////////////////////////////
    // pin input synchronisers
    tsg_sync #(.W(WW)) u_wsync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .d_in(wide_pin_in),
        .q_out(wide_sync)
    );

    tsg_sync #(.W(NW)) u_nsync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .d_in(narrow_pin_in),
        .q_out(narrow_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, answer on second edge
    assign req = avs_read | avs_write;
    assign hw_clr = hw_standby;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req & ~ack_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port registers; software standby leaves them alone
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdir_r <= tsg_pkg::WIDE_RST;
            wdat_r <= tsg_pkg::WIDE_RST;
        end else if (hw_clr) begin
            wdir_r <= tsg_pkg::WIDE_RST;
            wdat_r <= tsg_pkg::WIDE_RST;
        end else if (avs_write && ack_r) begin
            if (avs_address == tsg_pkg::WIDE_DIR_OFF) begin
                wdir_r <= avs_writedata[7:0];
            end
            if (avs_address == tsg_pkg::WIDE_DATA_OFF) begin
                wdat_r <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ndir_r <= tsg_pkg::NARROW_RST[2:0];
            ndat_r <= tsg_pkg::NARROW_RST[2:0];
        end else if (hw_clr) begin
            ndir_r <= tsg_pkg::NARROW_RST[2:0];
            ndat_r <= tsg_pkg::NARROW_RST[2:0];
        end else if (avs_write && ack_r) begin
            if (avs_address == tsg_pkg::NARROW_DIR_OFF) begin
                ndir_r <= avs_writedata[2:0];
            end
            if (avs_address == tsg_pkg::NARROW_DATA_OFF) begin
                ndat_r <= avs_writedata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: latch for outputs, pin for inputs
    assign wide_rd = (wdir_r & wdat_r) | (~wdir_r & wide_sync);
    assign narrow_rd = (ndir_r & ndat_r) | (~ndir_r & narrow_sync);

    always_comb begin
        rd_nxt = 8'h00;
        case (avs_address)
            tsg_pkg::WIDE_DATA_OFF: rd_nxt = wide_rd;
            tsg_pkg::NARROW_DIR_OFF: rd_nxt = tsg_pkg::NARROW_FILL;
            tsg_pkg::NARROW_DATA_OFF: begin
                rd_nxt = tsg_pkg::NARROW_FILL | {5'h00, narrow_rd};
            end
            default: rd_nxt = 8'h00;
        endcase
    end

    // direction registers are write-only; narrow reads back as the fill, wide as zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= {24'h00_0000, rd_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wide port pin drive; standby forces plain port behaviour
    logic [7:0] w_tsel;
    assign w_tsel = (sw_standby | hw_clr) ? 8'h00
        : (wide_tmr_sel & tsg_pkg::WIDE_OUT_PINS);

    genvar i;
    generate
        for (i = 0; i < WW; i++) begin : g_wide
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    wide_pin_out[i] <= 1'b0;
                    wide_pin_oe[i] <= 1'b0;
                    wide_pullup_en[i] <= 1'b0;
                end else if (w_tsel[i]) begin
                    wide_pin_out[i] <= wide_tmr_out[i];
                    wide_pin_oe[i] <= 1'b1;
                    wide_pullup_en[i] <= 1'b0;
                end else begin
                    wide_pin_out[i] <= wdat_r[i];
                    wide_pin_oe[i] <= wdir_r[i];
                    wide_pullup_en[i] <= ~wdir_r[i] & wdat_r[i];
                end
            end
        end
    endgenerate

    // timer inputs share the read path
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timer0_clock_in <= 1'b0;
            timer0_reset_in <= 1'b0;
            timer1_clock_in <= 1'b0;
            timer1_reset_in <= 1'b0;
        end else begin
            timer0_clock_in <= wide_rd[0];
            timer0_reset_in <= wide_rd[2];
            timer1_clock_in <= wide_rd[3];
            timer1_reset_in <= wide_rd[5];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // narrow port pin drive; standby forces plain port behaviour
    logic [2:0] n_ssel;
    logic [2:0] n_sdrv;
    assign n_ssel = (sw_standby | hw_clr) ? 3'h0 : ser_sel;
    assign n_sdrv = {async_clock_drive, 1'b0, async_transmit_line};

    generate
        for (i = 0; i < NW; i++) begin : g_narrow
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    narrow_pin_out[i] <= 1'b0;
                    narrow_pin_oe[i] <= 1'b0;
                    narrow_pullup_en[i] <= 1'b0;
                end else if (n_ssel[i]) begin
                    narrow_pin_out[i] <= n_sdrv[i];
                    // transmit always out, receive always
                    if (i == tsg_pkg::SER_TX_BIT) begin
                        narrow_pin_oe[i] <= 1'b1;
                        narrow_pullup_en[i] <= 1'b0;
                    end else if (i == tsg_pkg::SER_RX_BIT) begin
                        narrow_pin_oe[i] <= 1'b0;
                        narrow_pullup_en[i] <= ~ndir_r[i] & ndat_r[i];
                    end else begin
                        narrow_pin_oe[i] <= ser_oe[i];
                        narrow_pullup_en[i] <= ~ser_oe[i] & ~ndir_r[i]
                            & ndat_r[i];
                    end
                end else begin
                    narrow_pin_out[i] <= ndat_r[i];
                    narrow_pin_oe[i] <= ndir_r[i];
                    narrow_pullup_en[i] <= ~ndir_r[i] & ndat_r[i];
                end
            end
        end
    endgenerate

    // serial receive and clock inputs come straight from synchronised pins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            async_receive_line <= 1'b0;
            async_serial_clock <= 1'b0;
        end else begin
            async_receive_line <= narrow_sync[tsg_pkg::SER_RX_BIT];
            async_serial_clock <= narrow_sync[tsg_pkg::SER_CK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_wide_hw_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        hw_standby |=> (wdir_r == 8'h00 && wdat_r == 8'h00))
        else $error("wide regs not cleared");
    a_wide_hw_pins: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        hw_standby |=> ##1 (wide_pin_oe == 8'h00
        && wide_pullup_en == 8'h00))
        else $error("wide pins not plain inputs");
    a_narrow_hw_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        hw_standby |=> ##1 (narrow_pin_oe == 3'h0
        && narrow_pullup_en == 3'h0))
        else $error("narrow pins not plain inputs");
    a_wide_timer_drive: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        w_tsel[1] |=> (wide_pin_oe[1] && !wide_pullup_en[1]
        && wide_pin_out[1] == $past(wide_tmr_out[1])))
        else $error("timer output not driving");
    a_wide_port_dir: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (w_tsel == 8'h00) |=> (wide_pin_oe == $past(wdir_r)))
        else $error("wide direction mismatch");
    a_write_land: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (avs_write && ack_r && !hw_standby
        && avs_address == tsg_pkg::WIDE_DIR_OFF)
        |=> wdir_r == $past(avs_writedata[7:0]))
        else $error("direction write lost");
    a_pullup_latch: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (w_tsel[0] == 1'b0) |=> (wide_pullup_en[0]
        == ($past(~wdir_r[0]) & $past(wdat_r[0]))))
        else $error("pull-up wrong");
    a_read_mix: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (avs_read && !ack_r && avs_address == tsg_pkg::WIDE_DATA_OFF)
        |=> avs_readdata[7:0] == $past(wide_rd))
        else $error("read value wrong");
    a_narrow_read: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (avs_read && !ack_r && avs_address == tsg_pkg::NARROW_DATA_OFF)
        |=> avs_readdata[2:0] == $past(narrow_rd))
        else $error("narrow read value wrong");
    a_narrow_fill: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (avs_read && !ack_r && avs_address == tsg_pkg::NARROW_DATA_OFF)
        |=> avs_readdata[7:3] == 5'h1f)
        else $error("narrow fill bits wrong");
    a_timer_path: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ##1 timer0_clock_in == $past(wide_rd[0]))
        else $error("timer input not on read path");
    a_tx_drive: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        n_ssel[0] |=> (narrow_pin_oe[0] && !narrow_pullup_en[0]))
        else $error("transmit pin not driven");
    a_rx_input: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        n_ssel[1] |=> !narrow_pin_oe[1])
        else $error("receive pin driven");
    a_rx_pullup: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        n_ssel[1] |=> narrow_pullup_en[1]
        == $past(~ndir_r[1] & ndat_r[1]))
        else $error("receive pull-up wrong");
    a_clk_dir: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        n_ssel[2] |=> narrow_pin_oe[2] == $past(ser_oe[2]))
        else $error("clock pin direction wrong");
    a_narrow_plain: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (n_ssel == 3'h0) |=> narrow_pin_oe == $past(ndir_r))
        else $error("narrow direction mismatch");
    a_bus_answer: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (req && ack_r == 1'b0) |=> !avs_waitrequest)
        else $error("bus answer late");

    c_wide_write: cover property (@(posedge sys_clk) disable iff (!rstn)
        avs_write && !avs_waitrequest
        && avs_address == tsg_pkg::WIDE_DIR_OFF);
    c_timer_out: cover property (@(posedge sys_clk) disable iff (!rstn)
        w_tsel != 8'h00);
    c_serial_tx: cover property (@(posedge sys_clk) disable iff (!rstn)
        n_ssel[0]);
    c_sw_standby: cover property (@(posedge sys_clk) disable iff (!rstn)
        sw_standby && wdir_r != 8'h00);
endmodule
`default_nettype wire

// file: logic/tsg_sync.sv
// pin input synchroniser: three flops, change taken when last two agree
`timescale 1ns/1ps
`default_nettype none
module tsg_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    q_out[i] <= 1'b0;
                end else if (s2_r[i] == s3_r[i]) begin
                    q_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
